// file: hw/apb_cfg_pkg.sv
// Constants shared by the configuration fan-out and its target end
// Overview of operation
// - Hard DDR window 0x40020000-0x400203FF routed
// - 0x40020400-0x4002FFFF to fabric DDR, transceivers; code maps only 0x0400-0x07FF and 0x4000-0xBFFF, the rest errors
// - Each partition selects exactly one slave
// - Word addresses: master 15:2, DDR 10:2, transceiver 13:2
// - Master 32-bit data, DDR 16, transceiver 32
// - Write-direction high writes, low reads
// - Slave holds ready low; requester waits
// - Slave error returned to master port
// - Each port has own clock, own reset; here all ports share ref_clk, each with own reset
// - Select and enable active high
// - Bridge mirrors master and slave ports
// - All target accesses leave one master port
// - Without bridge, no target gets configured
// - Setup cycle, then enable, signals held
// - Complete on ready; enable, select then drop
package apb_cfg_pkg;
  localparam int NUM_PORTS = 4;
  // Port indices on the fan-out side
  localparam int PORT_HARD_DDR = 0;
  localparam int PORT_FABRIC_DDR = 1;
  localparam int PORT_SIF_A = 2;
  localparam int PORT_SIF_B = 3;
  // Widths
  localparam int MST_AW = 16;
  localparam int DDR_AW = 11;
  localparam int SIF_AW = 14;
  localparam int MST_DW = 32;
  localparam int DDR_DW = 16;
  localparam int SIF_DW = 32;
  // Configuration space base and the low 16-bit partition windows
  localparam logic [31:0] CFG_SPACE_BASE = 32'h4002_0000;
  localparam logic [15:0] HARD_DDR_FIRST = 16'h0000;
  localparam logic [15:0] HARD_DDR_LAST = 16'h03ff;
  localparam logic [15:0] FABRIC_DDR_FIRST = 16'h0400;
  localparam logic [15:0] FABRIC_DDR_LAST = 16'h07ff;
  localparam logic [15:0] SIF_A_FIRST = 16'h4000;
  localparam logic [15:0] SIF_A_LAST = 16'h7fff;
  localparam logic [15:0] SIF_B_FIRST = 16'h8000;
  localparam logic [15:0] SIF_B_LAST = 16'hbfff;
  // Read-data masks per port width
  localparam logic [31:0] DDR_DATA_MASK = 32'h0000_ffff;
  localparam logic [31:0] SIF_DATA_MASK = 32'hffff_ffff;
  localparam logic [3:0] RESET_SEL = 4'h0;
  localparam logic [31:0] RESET_DATA = 32'h0000_0000;
endpackage

// file: hw/apb_config_fanout.sv
// Fan-out from the single config master port to four APB slave ports
module apb_config_fanout (
  input wire logic ref_clk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic m_psel, // Master select
  input wire logic m_penable, // Master enable
  input wire logic m_pwrite, // Master direction, high writes
  input wire logic [15:2] m_paddr, // Master word address
  input wire logic [31:0] m_pwdata, // Master write data
  output logic [31:0] m_prdata, // Read data to master
  output logic m_pready, // Completion to master
  output logic m_pslverr, // Error to master
  apb_config_link.fanout link // Slave-port side
);
  // Timing of one mapped access, counted in rising edges:
  //   e0   master setup taken, target decoded, access latched
  //   e1   slave setup: one select high, enable low
  //   e2   slave access: enable high, select and access held
  //   eN   first edge with the selected ready high; reply taken
  //   eN+1 master samples ready, data and error, one cycle only
  // An unmapped access never reaches the link and is answered at e1,
  // with the error flag set and no wait state.
  // Every link output is a flop, so no combinational path runs from
  // the master pins to a slave pin; the price is two extra cycles.
  // Port order on the link: 0 hard DDR, 1 fabric DDR, 2 and 3 the
  // two serial transceiver interfaces.
  // DDR ports return only the low 16 data bits; their read data is
  // already zero above bit 15, so no masking is needed here.
  // Limitation: there is no time limit on a slave that never raises
  // ready, so a dead target stalls the master until reset.
  // Limitation: select always drops between accesses, even to the
  // same slave; the bus would allow keeping it.

  // One-hot sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1, // Waiting for a master setup cycle
    ST_SETUP = 4'h2, // Slave setup cycle on the link
    ST_ACCESS = 4'h4, // Slave access cycle, waits for ready
    ST_RESP = 4'h8 // Reply cycle towards the master
  } fan_state_e;

  // Sequencer state
  fan_state_e state_ff, nxt_state;

  // Slave-side strobes and access attributes
  logic [3:0] sel_ff, nxt_sel;
  logic en_ff, nxt_en;
  logic wr_ff, nxt_wr;
  logic [13:2] addr_ff, nxt_addr;
  logic [31:0] wdata_ff, nxt_wdata;

  // Master-side reply, registered so the reply comes from flops
  logic [31:0] rdata_ff, nxt_rdata;
  logic ready_ff, nxt_ready;
  logic err_ff, nxt_err;

  // Per-port resets, one cycle behind the block reset
  logic [3:0] port_rst_n_ff, nxt_port_rst_n;

  // Decode result and read data of the selected port
  logic [3:0] hit;
  logic [31:0] sel_rdata;

  // Address decode; windows never overlap so at most one bit is set.
  // Works on the byte offset inside the configuration space; the high
  // half of the full address is fixed by the master's own window.
  function automatic logic [3:0] decode(input logic [15:2] wa);
    logic [15:0] ba;
    logic [3:0] h;
    ba = {wa, 2'b00};
    h = 4'h0;
    h[apb_cfg_pkg::PORT_HARD_DDR] = (ba >= apb_cfg_pkg::HARD_DDR_FIRST) &&
      (ba <= apb_cfg_pkg::HARD_DDR_LAST);
    h[apb_cfg_pkg::PORT_FABRIC_DDR] = (ba >= apb_cfg_pkg::FABRIC_DDR_FIRST)
      && (ba <= apb_cfg_pkg::FABRIC_DDR_LAST);
    h[apb_cfg_pkg::PORT_SIF_A] = (ba >= apb_cfg_pkg::SIF_A_FIRST) &&
      (ba <= apb_cfg_pkg::SIF_A_LAST);
    h[apb_cfg_pkg::PORT_SIF_B] = (ba >= apb_cfg_pkg::SIF_B_FIRST) &&
      (ba <= apb_cfg_pkg::SIF_B_LAST);
    // A gap between windows leaves every bit clear
    return h;
  endfunction

  // Decode runs on the live master address but is used only in idle,
  // where a setup cycle guarantees that the address is valid
  assign hit = decode(m_paddr);

  // Read data of the selected port; unselected ports are ignored.
  // Select is one-hot, so the loop never merges two ports.
  always_comb begin
    sel_rdata = apb_cfg_pkg::RESET_DATA;
    for (int i = 0; i < apb_cfg_pkg::NUM_PORTS; i++) begin
      if (sel_ff[i]) begin
        sel_rdata = link.prdata[i];
      end
    end
  end

  // Transfer sequencer: master setup, slave setup, slave access, reply
  always_comb begin
    nxt_state = state_ff;
    nxt_sel = sel_ff;
    nxt_en = en_ff;
    nxt_wr = wr_ff;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_rdata = rdata_ff;
    nxt_ready = 1'b0;
    nxt_err = 1'b0;
    // Port resets trail the block reset by one flop
    nxt_port_rst_n = {4{rst_n}};
    case (state_ff)
      ST_IDLE: begin
        // Only a master setup cycle starts work
        if (m_psel && !m_penable) begin
          if (hit == 4'h0) begin
            // Answered in the master's first access cycle, no select
            nxt_ready = 1'b1;
            nxt_err = 1'b1;
            nxt_rdata = apb_cfg_pkg::RESET_DATA;
            nxt_state = ST_RESP;
          end else begin
            // Latch the whole access now, so the link never depends on
            // how long the master keeps its own signals steady
            nxt_sel = hit;
            nxt_wr = m_pwrite;
            nxt_addr = m_paddr[13:2];
            nxt_wdata = m_pwdata;
            nxt_state = ST_SETUP;
          end
        end
      end

      ST_SETUP: begin
        // Enable follows select by exactly one edge
        nxt_en = 1'b1;
        nxt_state = ST_ACCESS;
      end

      ST_ACCESS: begin
        // Stay here while the slave holds ready low; data and error
        // are taken only in the completing cycle
        if (|(sel_ff & link.pready)) begin
          nxt_rdata = sel_rdata;
          nxt_err = |(sel_ff & link.pslverr);
          nxt_ready = 1'b1;
          nxt_sel = apb_cfg_pkg::RESET_SEL;
          nxt_en = 1'b0;
          nxt_state = ST_RESP;
        end
      end

      ST_RESP: begin
        // The master still holds the finished access in this cycle,
        // so nothing is taken until the state is idle again
        nxt_state = ST_IDLE;
      end

      default: begin
        // Not reachable from reset; drop the strobes and start over
        nxt_sel = apb_cfg_pkg::RESET_SEL;
        nxt_en = 1'b0;
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Registers only; all groups take their reset values together
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      sel_ff <= apb_cfg_pkg::RESET_SEL;
      en_ff <= 1'b0;
      wr_ff <= 1'b0;
      addr_ff <= '0;
      wdata_ff <= apb_cfg_pkg::RESET_DATA;
      rdata_ff <= apb_cfg_pkg::RESET_DATA;
      ready_ff <= 1'b0;
      err_ff <= 1'b0;
      port_rst_n_ff <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      sel_ff <= nxt_sel;
      en_ff <= nxt_en;
      wr_ff <= nxt_wr;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      rdata_ff <= nxt_rdata;
      ready_ff <= nxt_ready;
      err_ff <= nxt_err;
      port_rst_n_ff <= nxt_port_rst_n;
    end
  end

  // All outputs come straight from flops, so a slave never sees a
  // glitch on its select while the decode settles
  // Link side
  assign link.psel = sel_ff;
  assign link.penable = en_ff;
  assign link.pwrite = wr_ff;
  assign link.paddr = addr_ff;
  assign link.pwdata = wdata_ff;
  assign link.preset_n = port_rst_n_ff;

  // Master side
  assign m_prdata = rdata_ff;
  assign m_pready = ready_ff;
  assign m_pslverr = err_ff;
endmodule

// file: hw/apb_config_link.sv
// Interface carrying the four APB configuration slave ports
interface apb_config_link;
  logic [3:0] psel;
  logic penable;
  logic pwrite;
  logic [13:2] paddr;
  logic [31:0] pwdata;
  logic [3:0] preset_n;
  logic [3:0][31:0] prdata;
  logic [3:0] pready;
  logic [3:0] pslverr;

  modport fanout (
    output psel, penable, pwrite, paddr, pwdata, preset_n,
    input prdata, pready, pslverr
  );
  modport target (
    input psel, penable, pwrite, paddr, pwdata, preset_n,
    output prdata, pready, pslverr
  );
endinterface

// file: hw/apb_config_targets.sv
// Target end: four APB configuration slaves handing accesses to user logic
module apb_config_targets (
  input wire logic ref_clk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  output logic [3:0] usr_req, // Access pending per port, level
  output logic usr_write, // Direction of pending access
  output logic [13:2] usr_addr, // Word address of pending access
  output logic [31:0] usr_wdata, // Write data of pending access
  input wire logic [3:0] usr_ack, // User completes access, pulse
  input wire logic [3:0][31:0] usr_rdata, // Read data with ack
  input wire logic [3:0] usr_err, // Failure flag with ack
  apb_config_link.target link // Slave-port side
);
  logic wr_ff, nxt_wr;
  logic [13:2] addr_ff, nxt_addr;
  logic [31:0] wdata_ff, nxt_wdata;

  // Access attributes captured in any setup cycle; one port at a time
  always_comb begin
    nxt_wr = wr_ff;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    if (|link.psel && !link.penable) begin
      nxt_wr = link.pwrite;
      nxt_addr = link.paddr;
      nxt_wdata = link.pwdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wr_ff <= 1'b0;
      addr_ff <= '0;
      wdata_ff <= apb_cfg_pkg::RESET_DATA;
    end else begin
      wr_ff <= nxt_wr;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
    end
  end

  assign usr_write = wr_ff;
  assign usr_addr = addr_ff;
  assign usr_wdata = wdata_ff;

  // One slave endpoint per port; DDR ports return only 16 read-data bits
  for (genvar i = 0; i < apb_cfg_pkg::NUM_PORTS; i++) begin : g_port
    localparam logic [31:0] MASK = (i < 2) ? apb_cfg_pkg::DDR_DATA_MASK :
      apb_cfg_pkg::SIF_DATA_MASK;
    logic req_ff, nxt_req;
    logic rdy_ff, nxt_rdy;
    logic err_ff, nxt_err;
    logic [31:0] rd_ff, nxt_rd;
    logic port_ok;

    // Port leaves reset only when both resets are released
    assign port_ok = rst_n && link.preset_n[i];

    // Ready stays low until user logic acknowledges
    always_comb begin
      nxt_req = req_ff;
      nxt_rdy = 1'b0;
      nxt_err = 1'b0;
      nxt_rd = rd_ff;
      if (link.psel[i] && !link.penable && !req_ff) begin
        nxt_req = 1'b1;
      end
      if (req_ff && usr_ack[i]) begin
        nxt_req = 1'b0;
        nxt_rdy = 1'b1;
        nxt_rd = usr_rdata[i] & MASK;
        nxt_err = usr_err[i];
      end
    end

    always_ff @(posedge ref_clk) begin
      if (!port_ok) begin
        req_ff <= 1'b0;
        rdy_ff <= 1'b0;
        err_ff <= 1'b0;
        rd_ff <= apb_cfg_pkg::RESET_DATA;
      end else begin
        req_ff <= nxt_req;
        rdy_ff <= nxt_rdy;
        err_ff <= nxt_err;
        rd_ff <= nxt_rd;
      end
    end

    assign usr_req[i] = req_ff;
    assign link.pready[i] = rdy_ff;
    assign link.pslverr[i] = err_ff;
    assign link.prdata[i] = rd_ff;
  end
endmodule

// file: verification/apb_config_chk.sv
// Checker on the link between the fan-out and the targets
module apb_config_chk (
  input wire logic ref_clk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic [3:0] psel, // Selects
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [13:2] paddr, // Address
  input wire logic [3:0] preset_n, // Port resets
  input wire logic [3:0][31:0] prdata, // Read data
  input wire logic [3:0] pready, // Ready
  input wire logic [3:0] pslverr // Error
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  a_one_select: assert property ($onehot0(psel))
    else $error("several selects");
  a_setup_enable: assert property (
    |psel && !penable |=> penable && $stable(psel))
    else $error("no enable after setup");
  a_access_held: assert property (
    penable |-> $stable(psel) && $stable(paddr) && $stable(pwrite))
    else $error("access changed");
  a_done_drops: assert property (
    penable && |(pready & psel) |=> !penable && psel == 4'h0)
    else $error("strobes held after done");
  a_ready_selected: assert property (
    |pready |-> penable && (pready & ~psel) == 4'h0)
    else $error("ready outside access");
  a_error_ready: assert property ((pslverr & ~pready) == 4'h0)
    else $error("error without ready");
  a_ddr_width: assert property (
    prdata[0][31:16] == 16'h0 && prdata[1][31:16] == 16'h0)
    else $error("wide data on 16-bit port");
  a_reset_follow: assert property (preset_n == {4{$past(rst_n)}})
    else $error("port reset off");
endmodule

// file: verification/tb_top.sv
// Testbench joining the fan-out to its target end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, rst_n = 1'b0, err_sel = 1'b0;
  logic m_psel = 1'b0, m_penable = 1'b0, m_pwrite = 1'b0;
  logic [15:2] m_paddr = '0;
  logic [31:0] m_pwdata = '0, m_prdata, usr_wdata, s_wd;
  logic m_pready, m_pslverr, usr_write, s_wr;
  logic [3:0] usr_req, s_port, usr_ack = '0, usr_err = '0;
  logic [13:2] usr_addr, s_addr;
  logic [3:0][31:0] usr_rdata = '0;
  int fails = 0, samples_checked = 0, dly = 0, acks = 0;
  apb_config_link link ();
  apb_config_fanout apb_config_fanout_inst (.ref_clk, .rst_n, .m_psel,
    .m_penable, .m_pwrite, .m_paddr, .m_pwdata, .m_prdata, .m_pready,
    .m_pslverr, .link(link));
  apb_config_targets apb_config_targets_inst (.ref_clk, .rst_n, .usr_req,
    .usr_write, .usr_addr, .usr_wdata, .usr_ack, .usr_rdata, .usr_err,
    .link(link));
  apb_config_chk apb_config_chk_inst (.ref_clk, .rst_n, .psel(link.psel),
    .penable(link.penable), .pwrite(link.pwrite), .paddr(link.paddr),
    .preset_n(link.preset_n), .prdata(link.prdata), .pready(link.pready),
    .pslverr(link.pslverr));
  always #4 ref_clk = ~ref_clk;
  // User side acks after dly cycles and holds ack one cycle, in which req falls, then idles one
  initial forever begin
    @(negedge ref_clk);
    if (|usr_req) begin
      repeat (dly) @(negedge ref_clk);
      s_port = usr_req;
      s_wr = usr_write;
      s_addr = usr_addr;
      s_wd = usr_wdata;
      usr_ack = usr_req;
      usr_rdata = {4{32'h9abc_5678}};
      usr_err = {4{err_sel}};
      acks++;
      @(negedge ref_clk);
      usr_ack = '0;
      usr_err = '0;
      @(negedge ref_clk);
    end
  end
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Expected port of a byte offset; -1 for the unmapped gaps
  function automatic int port_of(logic [15:0] a);
    if (a <= apb_cfg_pkg::HARD_DDR_LAST) return 0;
    if (a <= apb_cfg_pkg::FABRIC_DDR_LAST) return 1;
    if (a < apb_cfg_pkg::SIF_A_FIRST) return -1;
    if (a <= apb_cfg_pkg::SIF_A_LAST) return 2;
    if (a <= apb_cfg_pkg::SIF_B_LAST) return 3;
    return -1;
  endfunction
  // One access held until the edge that samples ready, then judged
  task automatic acc(logic w, logic [15:0] a, logic [31:0] d, logic xe);
    int p, n, a0;
    logic [31:0] m;
    p = port_of(a);
    m = p < 2 ? apb_cfg_pkg::DDR_DATA_MASK : apb_cfg_pkg::SIF_DATA_MASK;
    a0 = acks;
    n = 0;
    @(negedge ref_clk);
    m_psel = 1'b1;
    m_pwrite = w;
    m_paddr = a[15:2];
    m_pwdata = d;
    @(negedge ref_clk);
    m_penable = 1'b1;
    // Ready is read at falling edges, where it stands until the next rise
    while (m_pready !== 1'b1 && n < 300) begin
      n++;
      @(negedge ref_clk);
    end
    chk("ready", 32'h1, 32'(m_pready));
    chk("pslverr", 32'(p < 0 || xe), 32'(m_pslverr));
    if (!w && p >= 0 && !xe) begin
      chk("prdata", 32'h9abc_5678 & m, m_prdata);
    end
    // Hold the access through the edge that samples ready
    @(posedge ref_clk);
    @(negedge ref_clk);
    m_psel = 1'b0;
    m_penable = 1'b0;
    chk("acks", 32'(p < 0 ? a0 : a0 + 1), 32'(acks));
    if (p < 0) begin
      chk("waits", 32'h0, 32'(n));
    end else begin
      chk("waits", 32'(3 + dly), 32'(n));
      chk("port", 32'(1 << p), 32'(s_port));
      chk("dir", 32'(w), 32'(s_wr));
      chk("addr", 32'(p < 2 ? {3'h0, a[10:2]} : a[13:2]),
        32'(p < 2 ? {3'h0, s_addr[10:2]} : s_addr));
      if (w) chk("wdata", d & m, s_wd & m);
    end
  endtask
  // Window edges and unmapped gaps, write then read back to back
  task automatic t_windows();
    logic [15:0] tb [12] = '{16'h0000, 16'h03fc, 16'h0400, 16'h07fc,
      16'h0800, 16'h3ffc, 16'h4000, 16'h7ffc, 16'h8000, 16'hbffc,
      16'hc000, 16'hfffc};
    foreach (tb[i]) begin
      acc(1'b1, tb[i], {tb[i], ~tb[i]}, 1'b0);
      acc(1'b0, tb[i], 32'h0, 1'b0);
    end
  endtask
  // Slow target stretches the access
  task automatic t_wait();
    dly = 5;
    acc(1'b0, 16'h8010, 32'h0, 1'b0);
    acc(1'b1, 16'h0010, 32'h1234_abcd, 1'b0);
    dly = 0;
  endtask
  // Target failure is returned, then a clean access follows
  task automatic t_error();
    err_sel = 1'b1;
    acc(1'b1, 16'h0400, 32'h5555_aaaa, 1'b1);
    acc(1'b0, 16'h4004, 32'h0, 1'b1);
    err_sel = 1'b0;
    acc(1'b0, 16'h4004, 32'h0, 1'b0);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Reset for three cycles, then the scenarios
  initial begin
    repeat (3) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    t_windows();
    t_wait();
    t_error();
    finish_test();
  end
  // Watchdog far past the roughly 165 cycles the run needs
  initial begin
    #100000;
    fails++;
    finish_test();
  end
endmodule
